//--- dbm_ctrl.sv
// How it works
// RULE_01 - Data error: retry transfer up to ten times
// RULE_02 - Then recalibrate and retry ten more times
// RULE_03 - Both series failed: block has hard error
// RULE_04 - Hard error: run correction, schedule replacement
// RULE_05 - Hang check: seek0, read0, seek table, read
// RULE_06 - Save bad data plus recovery flag first
// RULE_07 - Save is done as write-check
// RULE_08 - Pattern write-check suspect block several times
// RULE_09 - Pattern pass: transient, restore data, no replace
// RULE_10 - Pattern fail: allocate new block, write data
// RULE_11 - Unrecovered data written with forced-error status; the code flags only the replacement write, not the restore
// RULE_12 - Track zero reserved, never holds user data
// RULE_13 - User area from spt to before table
// RULE_14 - Replacement table is exactly two tracks
// RULE_15 - Table tracks on different heads, identical copies
// RULE_16 - Blocks after table form replacement pool
// RULE_17 - Reserved region whole cylinders, about 0.1 percent
// RULE_18 - Blocks numbered from zero to total minus one
// RULE_19 - Removable drive: one unit, number equals drive
// RULE_20 - Shadow pair: writes duplicated, shadow hidden
// RULE_21 - Shadowed read goes to nearest heads
// RULE_22 - Sector size at least 595 bytes
// RULE_23 - Shadowed read error falls back to other drive
package dbm_pkg;
  localparam int PBA_W = 28;
  localparam logic [3:0] RETRY_MAX = 4'hA;
  localparam logic [10:0] MIN_BPS = 11'h253;
  localparam logic [12:0] RSV_DIV = 13'h3E8;
  localparam logic [12:0] RSV_RND = 13'h3E7;
  localparam logic [1:0] RCT_TRACKS = 2'h2;
  localparam logic [27:0] SAVE_OFS = 28'h0000001;
  localparam logic [2:0] PAT_LAST = 3'h3;
  localparam logic [4:0] TBL_DEPTH = 5'h10;
  localparam logic [1:0] HANG_LAST = 2'h3;

  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_WRCHK = 3'h2, OP_SEEK = 3'h3,
    OP_RECAL = 3'h4, OP_ECC = 3'h5, OP_PAT = 3'h6
  } dbm_op_t;

  typedef enum logic [2:0] {
    RSP_OK = 3'h0, RSP_RETRIED = 3'h1, RSP_REPLACED = 3'h2, RSP_FORCED = 3'h3,
    RSP_REJECT = 3'h4, RSP_HUNG = 3'h5, RSP_FULL = 3'h6, RSP_FAIL = 3'h7
  } dbm_resp_t;
endpackage : dbm_pkg

`timescale 1ns/10ps
module dbm_ctrl
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] cfg_spt,
  input wire logic [4:0] cfg_heads,
  input wire logic [11:0] cfg_cyls,
  input wire logic [10:0] cfg_bps,
  input wire logic [1:0] cfg_removable,
  input wire logic [3:0] cfg_unit0,
  input wire logic [3:0] cfg_unit1,
  input wire logic cfg_shadow_en,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [3:0] req_unit,
  input wire logic [27:0] req_lba,
  output logic req_ready,
  output logic resp_valid,
  output logic [2:0] resp_code,
  output logic drv_cmd_valid,
  output logic [2:0] drv_op,
  output logic drv_sel,
  output logic [27:0] drv_pba,
  output logic drv_force_err,
  output logic drv_ecc_flag,
  input wire logic drv_done,
  input wire logic drv_ok,
  input wire logic drv_ecc_ok
);
  typedef enum logic [12:0] {
    ST_IDLE = 13'h0001, ST_LOOK = 13'h0002, ST_XFER = 13'h0004, ST_RECAL = 13'h0008,
    ST_ECC = 13'h0010, ST_HANG = 13'h0020, ST_SAVE = 13'h0040, ST_PAT = 13'h0080,
    ST_RESTORE = 13'h0100, ST_ALLOC = 13'h0200, ST_WRREP = 13'h0400,
    ST_RCT = 13'h0800, ST_DONE = 13'h1000
  } dbm_state_t;

  function automatic logic [27:0] dbm_dist(input logic [27:0] a, input logic [27:0] b);
    dbm_dist = (a > b) ? a - b : b - a;
  endfunction : dbm_dist

  dbm_state_t st_r;
  logic pend_r, wr_r, shd_r, pass_r, fb_r, recal_r, ecc_ok_r, lk_ph_r, drv_r;
  logic [3:0] retry_r;
  logic [2:0] step_r;
  logic [4:0] cnt_r, scan_r;
  logic [27:0] pba_r, eff_r, newpba_r;
  logic [27:0] spt_r, rct_r, pool_r, last_r;
  logic [27:0] pos_r [2];
  logic tbl_we_r;
  logic [3:0] tbl_wa_r;
  logic [27:0] tbl_wd_r, tbl_rd;

  // Geometry; inputs are static configuration from the same clock domain
  wire [27:0] bpc_w = dbm_pkg::PBA_W'(cfg_spt) * dbm_pkg::PBA_W'(cfg_heads);
  wire [27:0] total_w = dbm_pkg::PBA_W'(bpc_w * dbm_pkg::PBA_W'(cfg_cyls)); // RULE_18
  // Whole cylinders, about one per thousand, rounded up
  wire [11:0] rsv_w = 12'((13'(cfg_cyls) + dbm_pkg::RSV_RND) / dbm_pkg::RSV_DIV); // RULE_17
  wire [27:0] rct_w = dbm_pkg::PBA_W'(dbm_pkg::PBA_W'(cfg_cyls - rsv_w) * bpc_w);
  wire [27:0] pool_w = rct_w + dbm_pkg::PBA_W'(dbm_pkg::RCT_TRACKS * 10'(cfg_spt)); // RULE_14 RULE_16

  // Request decode
  wire [3:0] unit_d0_w = cfg_removable[0] ? 4'h0 : cfg_unit0; // RULE_19
  wire [3:0] unit_d1_w = cfg_removable[1] ? 4'h1 : cfg_unit1; // RULE_19
  wire hit0_w = (req_unit == unit_d0_w);
  wire hit1_w = (req_unit == unit_d1_w) & ~hit0_w;
  wire hidden_w = cfg_shadow_en & hit1_w; // RULE_20
  wire fmt_ok_w = (cfg_bps >= dbm_pkg::MIN_BPS); // RULE_22
  wire [27:0] pba_req_w = spt_r + req_lba; // RULE_13
  wire in_rng_w = (req_lba < rct_r - spt_r) & (pba_req_w <= last_r); // RULE_12 RULE_13
  wire ok_req_w = fmt_ok_w & (hit0_w | hit1_w) & ~hidden_w & in_rng_w;
  wire shd_req_w = cfg_shadow_en & hit0_w;
  wire near1_w = dbm_dist(pba_req_w, pos_r[1]) < dbm_dist(pba_req_w, pos_r[0]); // RULE_21
  wire sel_w = shd_req_w ? (~req_write & near1_w) : hit1_w;
  wire take_w = req_valid & req_ready & (st_r == ST_IDLE);

  // Drive command handshake: one command outstanding at a time
  wire cmd_st_w = (st_r inside {ST_XFER, ST_RECAL, ST_ECC, ST_HANG, ST_SAVE, ST_PAT,
                                ST_RESTORE, ST_WRREP, ST_RCT});
  wire issue_w = cmd_st_w & ~pend_r;
  wire fin_w = pend_r & drv_done;
  wire tbl_hit_w = lk_ph_r & (tbl_rd == pba_r);
  wire [2:0] done_code_w = ecc_ok_r ? dbm_pkg::RSP_REPLACED : dbm_pkg::RSP_FORCED;
  // Pool ends at the last block; small drives may have none
  wire pool_full_w = (cnt_r == dbm_pkg::TBL_DEPTH)
                     | ((pool_r + dbm_pkg::PBA_W'(cnt_r)) > last_r); // RULE_16

  dbm_pkg::dbm_op_t op_w;
  logic [27:0] cpba_w;

  always_comb
  begin
    op_w = dbm_pkg::OP_WRITE;
    cpba_w = eff_r;
    unique case (st_r)
      ST_XFER: op_w = wr_r ? dbm_pkg::OP_WRITE : dbm_pkg::OP_READ;
      ST_RECAL: op_w = dbm_pkg::OP_RECAL;
      ST_ECC: op_w = dbm_pkg::OP_ECC; // RULE_04
      ST_HANG:
      begin
        op_w = step_r[0] ? dbm_pkg::OP_READ : dbm_pkg::OP_SEEK; // RULE_05
        cpba_w = step_r[1] ? rct_r : 28'h0000000; // RULE_05
      end
      ST_SAVE:
      begin
        op_w = dbm_pkg::OP_WRCHK; // RULE_07
        cpba_w = rct_r + dbm_pkg::SAVE_OFS; // RULE_06
      end
      ST_PAT: op_w = dbm_pkg::OP_PAT; // RULE_08
      ST_RESTORE: op_w = dbm_pkg::OP_WRITE; // RULE_09
      ST_WRREP: cpba_w = newpba_r; // RULE_10
      // Both copies written; second track sits under the next head
      ST_RCT: cpba_w = step_r[0] ? rct_r + spt_r : rct_r; // RULE_15
      default: cpba_w = eff_r;
    endcase
  end

  dbm_tbl u_tbl
  (
    .clock(clock),
    .reset(reset),
    .wr_en(tbl_we_r),
    .wr_addr(tbl_wa_r),
    .wr_data(tbl_wd_r),
    .rd_addr(scan_r[3:0]),
    .rd_data(tbl_rd)
  );

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      spt_r <= 28'h0000000;
      rct_r <= 28'h0000000;
      pool_r <= 28'h0000000;
      last_r <= 28'h0000000;
    end
    else
    begin
      spt_r <= dbm_pkg::PBA_W'(cfg_spt);
      rct_r <= rct_w;
      pool_r <= pool_w;
      last_r <= total_w - 28'h0000001; // RULE_18
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      drv_cmd_valid <= 1'b0;
      drv_op <= 3'h0;
      drv_sel <= 1'b0;
      drv_pba <= 28'h0000000;
      drv_force_err <= 1'b0;
      drv_ecc_flag <= 1'b0;
      pend_r <= 1'b0;
      pos_r[0] <= 28'h0000000;
      pos_r[1] <= 28'h0000000;
    end
    else
    begin
      drv_cmd_valid <= issue_w;
      if (issue_w)
      begin
        drv_op <= op_w;
        drv_sel <= drv_r;
        drv_pba <= cpba_w;
        drv_force_err <= (st_r == ST_WRREP) & ~ecc_ok_r; // RULE_11
        drv_ecc_flag <= ecc_ok_r; // RULE_06
        pos_r[drv_r] <= cpba_w;
        pend_r <= 1'b1;
      end
      else if (fin_w)
      begin
        pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_r <= ST_IDLE;
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_code <= 3'h0;
      {wr_r, shd_r, pass_r, fb_r, recal_r, ecc_ok_r, lk_ph_r, drv_r} <= 8'h00;
      retry_r <= 4'h0;
      step_r <= 3'h0;
      cnt_r <= 5'h00;
      scan_r <= 5'h00;
      pba_r <= 28'h0000000;
      eff_r <= 28'h0000000;
      newpba_r <= 28'h0000000;
      tbl_we_r <= 1'b0;
      tbl_wa_r <= 4'h0;
      tbl_wd_r <= 28'h0000000;
    end
    else
    begin
      resp_valid <= 1'b0;
      tbl_we_r <= 1'b0;
      unique case (st_r)
        ST_IDLE:
        begin
          req_ready <= 1'b1;
          if (take_w)
          begin
            req_ready <= 1'b0;
            pba_r <= pba_req_w;
            eff_r <= pba_req_w;
            wr_r <= req_write;
            shd_r <= shd_req_w;
            drv_r <= sel_w;
            {pass_r, fb_r, recal_r} <= 3'h0;
            retry_r <= 4'h0;
            scan_r <= 5'h00;
            lk_ph_r <= 1'b0;
            resp_code <= dbm_pkg::RSP_REJECT;
            st_r <= ok_req_w ? ST_LOOK : ST_DONE;
          end
        end
        ST_LOOK:
        begin
          // Linear scan trades latency for a tiny table
          lk_ph_r <= ~lk_ph_r;
          if (tbl_hit_w)
          begin
            eff_r <= pool_r + dbm_pkg::PBA_W'(scan_r); // RULE_16
            st_r <= ST_XFER;
          end
          else if (lk_ph_r)
          begin
            scan_r <= scan_r + 5'h01;
          end
          else if (scan_r == cnt_r)
          begin
            st_r <= ST_XFER;
          end
        end
        ST_XFER:
        begin
          if (fin_w & drv_ok)
          begin
            if (wr_r & shd_r & ~pass_r)
            begin
              pass_r <= 1'b1; // RULE_20
              drv_r <= 1'b1; // RULE_20
              retry_r <= 4'h0;
              recal_r <= 1'b0;
            end
            else
            begin
              resp_code <= (retry_r != 4'h0 | recal_r | fb_r) ? dbm_pkg::RSP_RETRIED
                                                            : dbm_pkg::RSP_OK;
              st_r <= ST_DONE;
            end
          end
          else if (fin_w & shd_r & ~wr_r & ~fb_r)
          begin
            fb_r <= 1'b1; // RULE_23
            drv_r <= ~drv_r; // RULE_23
          end
          else if (fin_w & (retry_r != dbm_pkg::RETRY_MAX))
          begin
            retry_r <= retry_r + 4'h1; // RULE_01
          end
          else if (fin_w)
          begin
            st_r <= recal_r ? ST_ECC : ST_RECAL; // RULE_02 RULE_03
          end
        end
        ST_RECAL:
        begin
          if (fin_w)
          begin
            recal_r <= 1'b1; // RULE_02
            retry_r <= 4'h0; // RULE_02
            st_r <= ST_XFER;
          end
        end
        ST_ECC:
        begin
          if (fin_w)
          begin
            ecc_ok_r <= drv_ok & drv_ecc_ok; // RULE_04
            step_r <= 3'h0;
            st_r <= ST_HANG; // RULE_04
          end
        end
        ST_HANG:
        begin
          if (fin_w)
          begin
            // A hung drive must not cost a good block
            step_r <= step_r + 3'h1;
            resp_code <= dbm_pkg::RSP_HUNG;
            st_r <= ~drv_ok ? ST_DONE : (step_r[1:0] == dbm_pkg::HANG_LAST) ? ST_SAVE
                                                                        : ST_HANG; // RULE_05
          end
        end
        ST_SAVE:
        begin
          if (fin_w)
          begin
            step_r <= 3'h0;
            resp_code <= dbm_pkg::RSP_FAIL;
            st_r <= drv_ok ? ST_PAT : ST_DONE; // RULE_07
          end
        end
        ST_PAT:
        begin
          if (fin_w)
          begin
            step_r <= step_r + 3'h1;
            if (~drv_ok)
            begin
              st_r <= ST_ALLOC; // RULE_10
            end
            else if (step_r == dbm_pkg::PAT_LAST)
            begin
              st_r <= ST_RESTORE; // RULE_09
            end
          end
        end
        ST_RESTORE:
        begin
          if (fin_w)
          begin
            resp_code <= drv_ok ? dbm_pkg::RSP_RETRIED : dbm_pkg::RSP_FAIL; // RULE_09
            st_r <= ST_DONE;
          end
        end
        ST_ALLOC:
        begin
          if (pool_full_w)
          begin
            resp_code <= dbm_pkg::RSP_FULL;
            st_r <= ST_DONE;
          end
          else
          begin
            tbl_we_r <= 1'b1; // RULE_10
            tbl_wa_r <= cnt_r[3:0];
            tbl_wd_r <= pba_r;
            newpba_r <= pool_r + dbm_pkg::PBA_W'(cnt_r); // RULE_10 RULE_16
            cnt_r <= cnt_r + 5'h01;
            st_r <= ST_WRREP;
          end
        end
        ST_WRREP:
        begin
          if (fin_w)
          begin
            step_r <= 3'h0;
            resp_code <= drv_ok ? done_code_w : dbm_pkg::RSP_FAIL;
            st_r <= drv_ok ? ST_RCT : ST_DONE;
          end
        end
        ST_RCT:
        begin
          if (fin_w)
          begin
            step_r <= step_r + 3'h1;
            if (~drv_ok)
            begin
              resp_code <= dbm_pkg::RSP_FAIL;
            end
            st_r <= (~drv_ok | step_r[0]) ? ST_DONE : ST_RCT; // RULE_15
          end
        end
        ST_DONE:
        begin
          resp_valid <= 1'b1;
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking dbm_cb @(posedge clock);
  endclocking
  default disable iff (reset);

  AST_RETRY_LIMIT: assert property (retry_r <= dbm_pkg::RETRY_MAX) // RULE_01
    else $error("retry count above ten");
  AST_RECAL_ENTRY: assert property ($rose(st_r == ST_RECAL)
      |-> $past(retry_r) == dbm_pkg::RETRY_MAX && !$past(recal_r)) // RULE_02
    else $error("recalibrate before ten retries");
  AST_HARD_ENTRY: assert property ($rose(st_r == ST_ECC)
      |-> recal_r && retry_r == dbm_pkg::RETRY_MAX) // RULE_03
    else $error("hard error before both retry series");
  AST_ECC_NEXT: assert property ((st_r == ST_ECC && fin_w)
      |=> st_r == ST_HANG && step_r == 3'h0) // RULE_04
    else $error("correction not followed by hang check");
  AST_HANG_ORDER: assert property ((drv_cmd_valid && st_r == ST_HANG)
      |-> drv_op == (step_r[0] ? dbm_pkg::OP_READ : dbm_pkg::OP_SEEK)
          && drv_pba == (step_r[1] ? rct_r : 28'h0000000)) // RULE_05
    else $error("hang check step out of order");
  AST_SAVE_CHK: assert property ((drv_cmd_valid && st_r == ST_SAVE)
      |-> drv_op == dbm_pkg::OP_WRCHK && drv_pba == rct_r + dbm_pkg::SAVE_OFS
          && drv_ecc_flag == ecc_ok_r) // RULE_06
    else $error("save is not a flagged write check");
  AST_PAT_PASS: assert property ((st_r == ST_PAT && fin_w && drv_ok && step_r == dbm_pkg::PAT_LAST)
      |=> st_r == ST_RESTORE ##1 drv_cmd_valid && drv_pba == eff_r) // RULE_09
    else $error("passed block not restored in place");
  AST_FORCE: assert property ((drv_cmd_valid && st_r == ST_WRREP)
      |-> drv_force_err == !ecc_ok_r && drv_pba == newpba_r) // RULE_11
    else $error("forced error flag wrong on replacement");
  AST_USER_AREA: assert property ((drv_cmd_valid && st_r == ST_XFER)
      |-> drv_pba >= spt_r) // RULE_12
    else $error("user transfer into track zero");
  AST_RCT_COPY: assert property ((drv_cmd_valid && st_r == ST_RCT && step_r[0])
      |-> drv_pba == rct_r + spt_r) // RULE_15
    else $error("second table copy misplaced");

  COV_REPLACED: cover property (resp_valid && resp_code == dbm_pkg::RSP_REPLACED);
  COV_RESTORED: cover property (st_r == ST_RESTORE && fin_w && drv_ok);
  COV_SHADOW_WR: cover property (st_r == ST_XFER && pass_r && fin_w && drv_ok);
  COV_FALLBACK: cover property ($rose(fb_r));
endmodule : dbm_ctrl

//--- dbm_tbl.sv
`timescale 1ns/10ps
module dbm_tbl
(
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [27:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [27:0] rd_data
);
  localparam int DEPTH = 16;

  // Contents need no reset; the owner tracks how many entries are valid
  logic [27:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rd_data <= 28'h0000000;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : dbm_tbl

//--- dbm_drv_model.sv
`timescale 1ns/10ps
module dbm_drv_model
(
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [2:0] op,
  input wire logic [27:0] pba,
  input wire logic arm,
  input wire logic [7:0] fail_n,
  input wire logic [27:0] bad_pba,
  input wire logic pat_fail,
  input wire logic ecc_good,
  input wire logic hang,
  output logic done,
  output logic ok,
  output logic ecc_ok
);
  logic busy_r, ok_r, tog_r, slow_r;
  logic [2:0] wait_r;
  logic [7:0] fails_r;
  // Lines toggle outside a completion, so a stale sample cannot pass
  assign ok = done ? ok_r : tog_r;
  assign ecc_ok = done ? ecc_good : ~tog_r;
  always_ff @(posedge clock)
  begin
    tog_r <= ~tog_r;
    done <= 1'b0;
    if (reset || arm)
    begin
      busy_r <= 1'b0;
      fails_r <= 8'h00;
      slow_r <= 1'b0;
      tog_r <= 1'b0;
    end
    else if (cmd_valid)
    begin
      busy_r <= 1'b1;
      // Alternate prompt and slow answers
      wait_r <= slow_r ? 3'h4 : 3'h0;
      slow_r <= ~slow_r;
      ok_r <= 1'b1;
      if (op == 3'h0 && pba == bad_pba && fails_r < fail_n)
      begin
        ok_r <= 1'b0;
        fails_r <= fails_r + 8'h01;
      end
      if (op == 3'h0 && pba == 28'h0000000 && hang)
        ok_r <= 1'b0;
      if (op == 3'h6 && pat_fail)
        ok_r <= 1'b0;
    end
    else if (busy_r)
    begin
      if (wait_r == 3'h0)
      begin
        done <= 1'b1;
        busy_r <= 1'b0;
      end
      wait_r <= wait_r - 3'h1;
    end
  end
endmodule : dbm_drv_model

//--- disc_error_recovery_and_block_map_test.sv
`timescale 1ns/10ps
module disc_error_recovery_and_block_map_test;
  typedef struct packed {logic w; logic [3:0] unit; logic [27:0] lba;
    logic [2:0] code; logic sel; logic [27:0] pba;} dbm_row_t;
  logic clock = 1'b0, reset = 1'b1;
  logic [10:0] bps = 11'h253;
  logic [1:0] rem = 2'h0;
  logic sh = 1'b0, req_valid = 1'b0, req_write = 1'b0, arm = 1'b0;
  logic [3:0] req_unit = 4'h0;
  logic [27:0] req_lba = 28'h0, bad = 28'h0;
  logic [7:0] fail_n = 8'h00;
  logic pat_fail = 1'b0, ecc_good = 1'b1, hang = 1'b0;
  logic req_ready, resp_valid, cv, sel, frc, flg, done, ok, eok;
  logic [2:0] resp_code, op, code;
  logic [27:0] pba;
  logic [33:0] log_q[$];
  int failures = 0, n_compared = 0, k, e;
  // Geometry 8 spt, 4 heads, 20 cyls: table at 608, pool at 624
  dbm_row_t rows[6] = '{
    '{1'b0, 4'h3, 28'h0, 3'h0, 1'b0, 28'h8},
    '{1'b1, 4'h3, 28'h127, 3'h0, 1'b0, 28'h12F},
    '{1'b0, 4'h3, 28'h258, 3'h4, 1'b0, 28'h0},
    '{1'b0, 4'h7, 28'h1, 3'h4, 1'b0, 28'h0},
    '{1'b1, 4'h5, 28'hA, 3'h0, 1'b1, 28'h12},
    '{1'b0, 4'h5, 28'h0, 3'h0, 1'b1, 28'h8}};
  initial forever #12.5 clock = ~clock;
  dbm_ctrl DUT (.clock(clock), .reset(reset), .cfg_spt(8'h08), .cfg_heads(5'h04),
    .cfg_cyls(12'h014), .cfg_bps(bps), .cfg_removable(rem), .cfg_unit0(4'h3),
    .cfg_unit1(4'h5), .cfg_shadow_en(sh), .req_valid(req_valid), .req_write(req_write),
    .req_unit(req_unit), .req_lba(req_lba), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_code(resp_code), .drv_cmd_valid(cv), .drv_op(op),
    .drv_sel(sel), .drv_pba(pba), .drv_force_err(frc), .drv_ecc_flag(flg),
    .drv_done(done), .drv_ok(ok), .drv_ecc_ok(eok));
  dbm_drv_model drv (.clock(clock), .reset(reset), .cmd_valid(cv), .op(op), .pba(pba),
    .arm(arm), .fail_n(fail_n), .bad_pba(bad), .pat_fail(pat_fail), .ecc_good(ecc_good),
    .hang(hang), .done(done), .ok(ok), .ecc_ok(eok));
  always @(posedge clock)
    if (cv === 1'b1)
      log_q.push_back({op, sel, frc, flg, pba});
  task automatic chk_val(input string what, input logic [27:0] exp, input logic [27:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_val
  task automatic chk_code(input logic [2:0] exp);
    chk_val("resp_code", {25'h0, exp}, {25'h0, code});
  endtask : chk_code
  task automatic chk_op(input int i, input logic [2:0] o, input logic [27:0] b);
    chk_val("drv_op", {25'h0, o}, {25'h0, log_q[i][33:31]});
    chk_val("drv_pba", b, log_q[i][27:0]);
  endtask : chk_op
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic rst(input logic [10:0] b, input logic [1:0] r, input logic s);
    @(posedge clock);
    reset <= 1'b1;
    bps <= b;
    rem <= r;
    sh <= s;
    repeat (8) @(posedge clock);
    #1 chk_val("outputs in reset", 28'h0, {25'h0, req_ready, resp_valid, cv});
    @(posedge clock);
    reset <= 1'b0;
  endtask : rst
  task automatic req(input logic w, input logic [3:0] u, input logic [27:0] l);
    @(posedge clock);
    arm <= 1'b1;
    log_q.delete();
    k = 0;
    do
    begin
      @(posedge clock);
      arm <= 1'b0;
      #1 k++;
    end
    while (req_ready !== 1'b1 && k < 50);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_unit <= u;
    req_lba <= l;
    @(posedge clock);
    req_valid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clock);
      #1 k++;
    end
    while (resp_valid !== 1'b1 && k < 4000);
    code = resp_code;
    if (k >= 4000)
      failures++;
  endtask : req
  function automatic int find(input logic [2:0] o, input logic [27:0] b);
    foreach (log_q[i])
      if (log_q[i][33:31] == o && log_q[i][27:0] == b)
        return i;
    return 0;
  endfunction : find
  initial
  begin
    #(25 * 80000);
    failures++;
    test_done();
  end
  initial
  begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      req(rows[i].w, rows[i].unit, rows[i].lba);
      chk_code(rows[i].code);
      chk_val("cmd count", (rows[i].code == 3'h0), log_q.size());
      if (rows[i].code == 3'h0 && log_q.size() > 0)
      begin
        chk_op(0, {2'h0, rows[i].w}, rows[i].pba);
        chk_val("drv_sel", rows[i].sel, log_q[0][30]);
      end
    end
    $display("test rows done");
    bad = 28'h30;
    fail_n = 8'h0A;
    req(1'b0, 4'h3, 28'h28);
    chk_code(3'h1);
    chk_val("recal after ten", 28'h0, find(3'h4, 28'h0) + find(3'h4, 28'h30));
    chk_val("reads", 28'hB, log_q.size());
    fail_n = 8'h0B;
    req(1'b0, 4'h3, 28'h28);
    chk_code(3'h1);
    chk_val("recal op", 28'h4, {25'h0, log_q[11][33:31]});
    $display("test retry done");
    fail_n = 8'hFF;
    req(1'b0, 4'h3, 28'h28);
    chk_code(3'h1);
    e = find(3'h5, bad);
    chk_val("reads before correction", 28'h16, e - 1);
    chk_val("tail length", e + 11, log_q.size());
    chk_op(e + 1, 3'h3, 28'h0);
    chk_op(e + 2, 3'h0, 28'h0);
    chk_op(e + 3, 3'h3, 28'h260);
    chk_op(e + 4, 3'h0, 28'h260);
    chk_op(e + 5, 3'h2, 28'h261);
    chk_val("save flag", 28'h1, log_q[e + 5][28]);
    for (int i = 6; i < 10; i++)
      chk_op(e + i, 3'h6, bad);
    chk_op(e + 10, 3'h1, bad);
    $display("test transient done");
    bad = 28'h44;
    pat_fail = 1'b1;
    ecc_good = 1'b0;
    req(1'b0, 4'h3, 28'h3C);
    chk_code(3'h3);
    e = find(3'h1, 28'h270);
    chk_val("save flag", 28'h0, log_q[find(3'h2, 28'h261)][28]);
    chk_val("forced", 28'h1, log_q[e][29]);
    chk_op(e + 1, 3'h1, 28'h260);
    chk_op(e + 2, 3'h1, 28'h268);
    pat_fail = 1'b0;
    fail_n = 8'h00;
    req(1'b0, 4'h3, 28'h3C);
    chk_code(3'h0);
    chk_op(0, 3'h0, 28'h270);
    $display("test replace done");
    hang = 1'b1;
    fail_n = 8'hFF;
    bad = 28'h58;
    req(1'b0, 4'h3, 28'h50);
    chk_code(3'h5);
    chk_val("no save", 28'h0, find(3'h2, 28'h261));
    hang = 1'b0;
    fail_n = 8'h00;
    $display("test hang done");
    rst(11'h252, 2'h0, 1'b0);
    req(1'b0, 4'h3, 28'h0);
    chk_code(3'h4);
    rst(11'h253, 2'h1, 1'b0);
    req(1'b0, 4'h0, 28'h5);
    chk_code(3'h0);
    chk_op(0, 3'h0, 28'hD);
    req(1'b0, 4'h3, 28'h5);
    chk_code(3'h4);
    rst(11'h253, 2'h0, 1'b1);
    req(1'b1, 4'h3, 28'h7);
    chk_code(3'h0);
    chk_val("dup count", 28'h2, log_q.size());
    chk_val("dup sels", 28'h1, {log_q[0][30], log_q[1][30]});
    chk_op(1, 3'h1, 28'hF);
    bad = 28'hF;
    fail_n = 8'h01;
    req(1'b0, 4'h3, 28'h7);
    chk_code(3'h1);
    chk_val("fallback sels", 28'h1, {log_q[0][30], log_q[1][30]});
    fail_n = 8'h00;
    req(1'b0, 4'h3, 28'h100);
    req(1'b0, 4'h3, 28'h7);
    chk_code(3'h0);
    chk_val("nearest sel", 28'h1, log_q[0][30]);
    req(1'b0, 4'h5, 28'h7);
    chk_code(3'h4);
    $display("test reset and units done");
    test_done();
  end
endmodule : disc_error_recovery_and_block_map_test
